// File: rtl/pmon_pkg.sv
package pmon_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CONV_CFG = 8'h04;
  localparam logic [7:0] OFS_DIAG = 8'h08;
  localparam logic [7:0] OFS_LIMIT0 = 8'h0C;
  localparam int NUM_LIMITS = 6;
  // Limit index order
  localparam int LIM_CUR_LOW = 0;
  localparam int LIM_CUR_HIGH = 1;
  localparam int LIM_RAIL_HIGH = 2;
  localparam int LIM_RAIL_LOW = 3;
  localparam int LIM_HEAT = 4;
  localparam int LIM_POWER = 5;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_SW_RESET_BIT = 15;
  localparam int DIAG_DONE_BIT = 6;
  localparam int DIAG_MATH_BIT = 7;
  localparam int DIAG_TRIM_BIT = 8;
  localparam int DIAG_ENERGY_BIT = 9;
  localparam int DIAG_CHARGE_BIT = 10;
  localparam int DIAG_AVG_BIT = 12;
  localparam int DIAG_POL_BIT = 13;
  localparam int DIAG_RDY_BIT = 14;
  localparam int DIAG_LATCH_BIT = 15;
  // ****************************************
  // Reset values and mode codes
  // ****************************************
  localparam logic [15:0] RST_CUR_LOW = 16'h8000;
  localparam logic [15:0] RST_POS_MAX = 16'h7FFF;
  localparam logic [15:0] RST_RAIL_LOW = 16'h0000;
  localparam logic [15:0] RST_HEAT = 16'hFFFF;
  localparam logic [1:0] MODE_SHUT = 2'h0;
  localparam logic [1:0] MODE_TRIG = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;

  typedef enum {ST_SHUT, ST_TRIG, ST_CONT} conv_state_type;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] rail;
    logic [15:0] heat;
    logic [15:0] power;
  } result_type;

  typedef struct packed {
    logic math;
    logic energy;
    logic charge;
  } ovf_event_type;
endpackage : pmon_pkg

// File: rtl/power_monitor_alert_logic.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module power_monitor_alert_logic
  import pmon_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire result_type sample,
  input wire logic cycle_done,
  input wire result_type average,
  input wire ovf_event_type ovf_event,
  input wire logic trim_ok,
  output logic conv_start,
  output logic conv_run,
  output logic alert_out,
  output logic alert_oe
);
  // ****************************************
  // Bus decode
  // ****************************************
  logic srst_r;
  logic rst_all;
  logic acc_done;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_word;
  logic rd_hit;
  logic diag_read;
  logic mode_write;
  logic [1:0] mode_wdata;
  logic [15:0] limit_r [NUM_LIMITS];
  logic [5:0] lim_flag_r;
  logic [5:0] lim_hit;
  logic done_flag_r;
  logic math_flag_r;
  logic energy_flag_r;
  logic charge_flag_r;
  logic trim_flag_r;
  logic latch_en_r;
  logic rdy_en_r;
  logic avg_en_r;
  logic pol_r;
  logic [1:0] mode_r;
  logic cmp_event;
  result_type cmp_data;
  logic alert_active;
  conv_state_type state_r;

  assign rst_all = rst | srst_r;
  assign acc_done = psel & penable & pready;
  assign wr_en = acc_done & pwrite;
  assign rd_en = acc_done & ~pwrite;
  assign diag_read = rd_en && paddr == OFS_DIAG;
  assign mode_write = wr_en && paddr == OFS_CONV_CFG;
  assign mode_wdata = pwdata[1:0];

  function automatic logic lim_sel(input logic [7:0] a, input int i);
    lim_sel = a == OFS_LIMIT0 + 8'(4 * i);
  endfunction : lim_sel

  // Signed compare for current and power, unsigned for rail and heat
  function automatic logic above(input logic [15:0] v, input logic [15:0] l, input logic sgn);
    above = sgn ? ($signed(v) > $signed(l)) : (v > l);
  endfunction : above

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      OFS_CONFIG: rd_word = 32'h0000_0000;
      OFS_CONV_CFG: rd_word = {30'h0000_0000, mode_r};
      OFS_DIAG: begin
        rd_word[5:0] = lim_flag_r;
        rd_word[DIAG_DONE_BIT] = done_flag_r;
        rd_word[DIAG_MATH_BIT] = math_flag_r;
        rd_word[DIAG_TRIM_BIT] = trim_flag_r;
        rd_word[DIAG_ENERGY_BIT] = energy_flag_r;
        rd_word[DIAG_CHARGE_BIT] = charge_flag_r;
        rd_word[DIAG_AVG_BIT] = avg_en_r;
        rd_word[DIAG_POL_BIT] = pol_r;
        rd_word[DIAG_RDY_BIT] = rdy_en_r;
        rd_word[DIAG_LATCH_BIT] = latch_en_r;
      end
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NUM_LIMITS; i++) begin
          if (lim_sel(paddr, i)) begin
            rd_hit = 1'b1;
            rd_word = {16'h0000, limit_r[i]};
          end
        end
      end
    endcase
  end

  // One wait state; answer registered, valid in any mode
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite & rd_hit) ? rd_word : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~rd_hit;
    end
  end

  // Self-clearing pulse; reset only by the pin so it cannot hold itself
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      srst_r <= 1'b0;
    end else begin
      srst_r <= wr_en && paddr == OFS_CONFIG && pwdata[CFG_SW_RESET_BIT];
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      limit_r[LIM_CUR_LOW] <= RST_CUR_LOW;
      limit_r[LIM_CUR_HIGH] <= RST_POS_MAX;
      limit_r[LIM_RAIL_HIGH] <= RST_POS_MAX;
      limit_r[LIM_RAIL_LOW] <= RST_RAIL_LOW;
      limit_r[LIM_HEAT] <= RST_HEAT;
      limit_r[LIM_POWER] <= RST_POS_MAX;
    end else begin
      for (int i = 0; i < NUM_LIMITS; i++) begin
        if (wr_en && lim_sel(paddr, i)) begin
          limit_r[i] <= pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      latch_en_r <= 1'b0;
      rdy_en_r <= 1'b0;
      avg_en_r <= 1'b0;
      pol_r <= 1'b0;
      mode_r <= MODE_SHUT;
    end else begin
      if (wr_en && paddr == OFS_DIAG) begin
        latch_en_r <= pwdata[DIAG_LATCH_BIT];
        rdy_en_r <= pwdata[DIAG_RDY_BIT];
        avg_en_r <= pwdata[DIAG_AVG_BIT];
        pol_r <= pwdata[DIAG_POL_BIT];
      end
      if (mode_write) begin
        mode_r <= mode_wdata;
      end else if (state_r == ST_TRIG && cycle_done) begin
        mode_r <= MODE_SHUT;
      end
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      state_r <= ST_SHUT;
      conv_start <= 1'b0;
      conv_run <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (mode_write) begin
        // Restart even mid-cycle; the converter drops partial work
        conv_start <= mode_wdata == MODE_TRIG || mode_wdata == MODE_CONT;
        conv_run <= mode_wdata == MODE_TRIG || mode_wdata == MODE_CONT;
        case (mode_wdata)
          MODE_TRIG: state_r <= ST_TRIG;
          MODE_CONT: state_r <= ST_CONT;
          default: state_r <= ST_SHUT;
        endcase
      end else begin
        case (state_r)
          ST_SHUT: state_r <= ST_SHUT;
          ST_TRIG: begin
            if (cycle_done) begin
              state_r <= ST_SHUT;
              conv_run <= 1'b0;
            end
          end
          ST_CONT: conv_start <= cycle_done;
          default: state_r <= ST_SHUT;
        endcase
      end
    end
  end

  // ****************************************
  // Limit compare and status
  // ****************************************
  assign cmp_event = (state_r != ST_SHUT) && (avg_en_r ? cycle_done : sample_valid);
  assign cmp_data = avg_en_r ? average : sample;

  always_comb begin
    lim_hit[LIM_CUR_LOW] = above(limit_r[LIM_CUR_LOW], cmp_data.current, 1'b1);
    lim_hit[LIM_CUR_HIGH] = above(cmp_data.current, limit_r[LIM_CUR_HIGH], 1'b1);
    lim_hit[LIM_RAIL_HIGH] = above(cmp_data.rail, limit_r[LIM_RAIL_HIGH], 1'b0);
    lim_hit[LIM_RAIL_LOW] = above(limit_r[LIM_RAIL_LOW], cmp_data.rail, 1'b0);
    lim_hit[LIM_HEAT] = above(cmp_data.heat, limit_r[LIM_HEAT], 1'b0);
    lim_hit[LIM_POWER] = above(cmp_data.power, limit_r[LIM_POWER], 1'b1);
  end

  // Latched flags are sticky until a status read; a new hit wins over it
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      lim_flag_r <= 6'h00;
    end else if (cmp_event) begin
      lim_flag_r <= latch_en_r && !diag_read ? lim_flag_r | lim_hit : lim_hit;
    end else if (diag_read && latch_en_r) begin
      lim_flag_r <= 6'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      done_flag_r <= 1'b0;
    end else if (cycle_done && state_r != ST_SHUT) begin
      done_flag_r <= 1'b1;
    end else if (diag_read || (mode_write && mode_wdata != MODE_SHUT)) begin
      done_flag_r <= 1'b0;
    end
  end

  // Overflow flags clear on status read; a coincident event wins
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      math_flag_r <= 1'b0;
      energy_flag_r <= 1'b0;
      charge_flag_r <= 1'b0;
      trim_flag_r <= 1'b0;
    end else begin
      math_flag_r <= ovf_event.math | (math_flag_r & ~diag_read);
      energy_flag_r <= ovf_event.energy | (energy_flag_r & ~diag_read);
      charge_flag_r <= ovf_event.charge | (charge_flag_r & ~diag_read);
      trim_flag_r <= trim_ok;
    end
  end

  // ****************************************
  // Alert pin
  // ****************************************
  // Overflow and health flags deliberately absent here
  assign alert_active = (|lim_flag_r) | (rdy_en_r & done_flag_r);

  // Pin low when asserted with polarity clear; high level from pull-up
  always_ff @(posedge clk_sys) begin
    if (rst_all) begin
      alert_oe <= 1'b0;
      alert_out <= 1'b0;
    end else begin
      alert_oe <= alert_active ^ pol_r;
      alert_out <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_done_set;
    @(posedge clk_sys) disable iff (rst_all)
    cycle_done && state_r != ST_SHUT |=> done_flag_r;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_done_clear;
    @(posedge clk_sys) disable iff (rst_all)
    diag_read && !cycle_done |=> !done_flag_r;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_latch_hold;
    @(posedge clk_sys) disable iff (rst_all)
    latch_en_r && (|lim_flag_r) && !diag_read |=> (lim_flag_r & $past(lim_flag_r)) == $past(lim_flag_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag lost");

  property p_pol;
    @(posedge clk_sys) disable iff (rst_all)
    !(|lim_flag_r) && !(rdy_en_r && done_flag_r) ##1 !$past(srst_r) |-> alert_oe == $past(pol_r);
  endproperty
  a_pol: assert property (p_pol) else $error("idle alert level wrong");

  property p_alert_hit;
    @(posedge clk_sys) disable iff (rst_all)
    cmp_event && |lim_hit && !pol_r && !(wr_en && paddr == OFS_DIAG) |-> ##2 alert_oe;
  endproperty
  a_alert_hit: assert property (p_alert_hit) else $error("alert missed a limit");

  property p_od;
    @(posedge clk_sys) alert_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("alert pin driven high");

  property p_shut_stay;
    @(posedge clk_sys) disable iff (rst_all)
    state_r == ST_SHUT && !mode_write |=> state_r == ST_SHUT && !conv_start;
  endproperty
  a_shut_stay: assert property (p_shut_stay) else $error("left shutdown alone");

  property p_trig_back;
    @(posedge clk_sys) disable iff (rst_all)
    state_r == ST_TRIG && cycle_done && !mode_write |=> state_r == ST_SHUT && mode_r == MODE_SHUT;
  endproperty
  a_trig_back: assert property (p_trig_back) else $error("trigger did not return");

  property p_restart;
    @(posedge clk_sys) disable iff (rst_all)
    mode_write && mode_wdata == MODE_CONT |=> conv_start && conv_run;
  endproperty
  a_restart: assert property (p_restart) else $error("mode write no restart");

  property p_swreset;
    @(posedge clk_sys) disable iff (rst)
    wr_en && paddr == OFS_CONFIG && pwdata[CFG_SW_RESET_BIT] |=> ##1 limit_r[LIM_CUR_LOW] == RST_CUR_LOW;
  endproperty
  a_swreset: assert property (p_swreset) else $error("software reset ignored");

  property p_unlatched;
    @(posedge clk_sys) disable iff (rst_all)
    cmp_event && !latch_en_r && !(|lim_hit) |=> lim_flag_r == 6'h00;
  endproperty
  a_unlatched: assert property (p_unlatched) else $error("flag stuck unlatched");

  c_latched_read: cover property (@(posedge clk_sys) latch_en_r && |lim_flag_r ##1 diag_read);
  c_trig_cycle: cover property (@(posedge clk_sys) state_r == ST_TRIG ##[1:50] state_r == ST_SHUT);
  c_ready_alert: cover property (@(posedge clk_sys) rdy_en_r && done_flag_r && !(|lim_flag_r));
  c_cont_restart: cover property (@(posedge clk_sys) state_r == ST_CONT && cycle_done);
endmodule : power_monitor_alert_logic

// File: test/alert_host.sv
`timescale 1ns/1ps
// ****************************************
// Host watching the shared alert line
// ****************************************
module alert_host (
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic polarity,
  output logic pin,
  output logic asserted
);
  // Pull-up wins unless the device sinks the line
  assign pin = alert_oe ? alert_out : 1'b1;
  // Low means alert unless the polarity is inverted
  assign asserted = polarity ? pin : !pin;
endmodule : alert_host

// File: test/power_monitor_alert_logic_test.sv
`timescale 1ns/1ps
module power_monitor_alert_logic_test;
  import pmon_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err, power_high_flag;
  logic sample_valid, cycle_done, trim_ok, conv_start, conv_run, alert_out, alert_oe, pin, asserted;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  result_type sample, average;
  ovf_event_type ovf_event;
  int num_errors, num_checks, starts, s;
  logic [15:0] dflt [NUM_LIMITS] = '{RST_CUR_LOW, RST_POS_MAX, RST_POS_MAX, RST_RAIL_LOW, RST_HEAT, RST_POS_MAX};
  power_monitor_alert_logic u_power_monitor_alert_logic (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample(sample), .cycle_done(cycle_done),
    .average(average), .ovf_event(ovf_event), .trim_ok(trim_ok), .conv_start(conv_start),
    .conv_run(conv_run), .alert_out(alert_out), .alert_oe(alert_oe));
  alert_host u_alert_host (.alert_out(alert_out), .alert_oe(alert_oe), .polarity(power_high_flag), .pin(pin),
    .asserted(asserted));
  // ****************************************
  // Clock, start counter, watchdog
  // ****************************************
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (conv_start === 1'b1) starts <= starts + 1;
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // No local limit; a hung slave is caught by the watchdog
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task pulse(input logic avg, input logic [15:0] cur);
    @(posedge clk_sys);
    if (avg) begin
      cycle_done <= 1;
      average <= '{current: cur, default: 16'h0000};
    end else begin
      sample_valid <= 1;
      sample <= '{current: cur, default: 16'h0000};
    end
    @(posedge clk_sys);
    cycle_done <= 0;
    sample_valid <= 0;
  endtask : pulse
  task alert(input logic exp);
    repeat (3) @(posedge clk_sys);
    chk(32'(asserted), 32'(exp));
    chk(32'(alert_out), 32'h0);
  endtask : alert
  task hw_reset();
    @(posedge clk_sys);
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    power_high_flag = 0;
  endtask : hw_reset
  task over_cont();
    apb(1, OFS_LIMIT0 + 8'h04, 32'h0100);
    apb(1, OFS_CONV_CFG, 32'(MODE_CONT));
  endtask : over_cont
  task conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // ****************************************
  // Scenarios
  // ****************************************
  task t_defaults();
    for (int i = 0; i < NUM_LIMITS; i++) begin
      apb(0, OFS_LIMIT0 + 8'(4 * i), 32'h0);
      chk(q, 32'(dflt[i]));
    end
    apb(0, OFS_DIAG, 32'h0);
    chk(q, 32'h0000_0100);
    apb(0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    apb(1, OFS_LIMIT0 + 8'h14, 32'h1234);
    apb(0, OFS_LIMIT0 + 8'h14, 32'h0);
    chk(q, 32'h1234);
    alert(0);
    $display("test defaults done");
  endtask : t_defaults
  task t_limit();
    over_cont();
    pulse(0, 16'h0100);
    alert(0);
    pulse(0, 16'h0101);
    alert(1);
    apb(0, OFS_DIAG, 32'h0);
    chk(32'(q[5:0]), 32'h02);
    pulse(0, 16'h0000);
    alert(0);
    hw_reset();
    $display("test limit done");
  endtask : t_limit
  task t_latch();
    apb(1, OFS_DIAG, 32'h8000);
    over_cont();
    pulse(0, 16'h0200);
    pulse(0, 16'h0000);
    alert(1);
    apb(0, OFS_DIAG, 32'h0);
    chk(32'(q[1]), 32'h1);
    alert(0);
    hw_reset();
    $display("test latch done");
  endtask : t_latch
  task t_ready();
    apb(1, OFS_CONV_CFG, 32'(MODE_CONT));
    apb(1, OFS_DIAG, 32'h4000);
    pulse(1, 16'h0000);
    alert(1);
    apb(0, OFS_DIAG, 32'h0);
    chk(32'(q[6]), 32'h1);
    alert(0);
    apb(1, OFS_DIAG, 32'h0);
    pulse(1, 16'h0000);
    alert(0);
    apb(1, OFS_CONV_CFG, 32'(MODE_CONT));
    apb(0, OFS_DIAG, 32'h0);
    chk(32'(q[6]), 32'h0);
    hw_reset();
    $display("test ready done");
  endtask : t_ready
  task t_avg();
    apb(1, OFS_DIAG, 32'h1000);
    over_cont();
    pulse(0, 16'h0200);
    alert(0);
    pulse(1, 16'h0200);
    alert(1);
    hw_reset();
    $display("test avg done");
  endtask : t_avg
  task t_pol();
    power_high_flag = 1;
    apb(1, OFS_DIAG, 32'h2000);
    alert(0);
    chk(32'(alert_oe), 32'h1);
    over_cont();
    pulse(0, 16'h0200);
    alert(1);
    hw_reset();
    $display("test pol done");
  endtask : t_pol
  task t_ovf();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      ovf_event <= 3'(1 << k);
      @(posedge clk_sys);
      ovf_event <= 3'h0;
      alert(0);
    end
    apb(0, OFS_DIAG, 32'h0);
    chk(32'({q[10:9], q[7]}), 32'h7);
    trim_ok <= 0;
    apb(0, OFS_DIAG, 32'h0);
    chk(32'(q[8]), 32'h0);
    trim_ok <= 1;
    $display("test ovf done");
  endtask : t_ovf
  task t_mode();
    apb(1, OFS_LIMIT0 + 8'h04, 32'h0100);
    apb(0, OFS_LIMIT0 + 8'h04, 32'h0);
    chk(q, 32'h0100);
    pulse(0, 16'h0200);
    alert(0);
    chk(32'(conv_run), 32'h0);
    s = starts;
    apb(1, OFS_CONV_CFG, 32'(MODE_TRIG));
    repeat (3) @(posedge clk_sys);
    chk(32'(starts), 32'(s + 1));
    chk(32'(conv_run), 32'h1);
    pulse(1, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk(32'(conv_run), 32'h0);
    apb(0, OFS_CONV_CFG, 32'h0);
    chk(32'(q[1:0]), 32'h0);
    apb(1, OFS_CONV_CFG, 32'(MODE_CONT));
    apb(1, OFS_CONV_CFG, 32'(MODE_CONT));
    repeat (3) @(posedge clk_sys);
    chk(32'(starts), 32'(s + 3));
    apb(1, OFS_CONV_CFG, 32'h3);
    apb(0, OFS_CONV_CFG, 32'h0);
    chk(q, 32'h3);
    chk(32'(conv_run), 32'h0);
    chk(32'(starts), 32'(s + 3));
    hw_reset();
    $display("test mode done");
  endtask : t_mode
  task t_swrst();
    apb(1, OFS_LIMIT0, 32'h1234);
    apb(1, OFS_CONFIG, 32'h8000);
    repeat (4) @(posedge clk_sys);
    apb(0, OFS_LIMIT0, 32'h0);
    chk(q, 32'h8000);
    apb(0, OFS_CONFIG, 32'h0);
    chk(q, 32'h0);
    $display("test swrst done");
  endtask : t_swrst
  initial begin
    {rst, psel, penable, pwrite, sample_valid, cycle_done, power_high_flag} = 7'h40;
    {paddr, pwdata, sample, average, ovf_event} = '0;
    trim_ok = 1;
    starts = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    t_defaults();
    t_limit();
    t_latch();
    t_ready();
    t_avg();
    t_pol();
    t_ovf();
    t_mode();
    t_swrst();
    conclude();
  end
endmodule : power_monitor_alert_logic_test
